//--- design/djlh_ctrl.sv
// Purpose : jog, limit switch and halt parameter control of a motor drive
// Assumes : parameter port is synchronous; one access per strobe
// Notes   : writes outside a parameter's range are refused and flagged
`include "djlh_regs.svh"
`default_nettype none

module djlh_ctrl #(
  parameter int unsigned MS_CYCLES    = `DJLH_MS_CYCLES,
  parameter logic [15:0] HALT_CUR_RST = 16'h0064
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // parameter access
  input  wire logic [15:0] par_addr,
  input  wire logic        par_wr,
  input  wire logic        par_rd,
  input  wire logic [31:0] par_wdata,
  output logic      [31:0] par_rdata,
  output logic             par_ack,
  output logic             par_err,
  // switch inputs
  input  wire logic        positive_limit_input,
  input  wire logic        ref_switch_input,
  input  wire logic        homing_active,
  // drive context
  input  wire logic [15:0] max_ramp_speed,
  input  wire logic [31:0] decel_ramp_setting,
  input  wire logic [15:0] current_ceiling,
  input  wire logic        mode_has_profile_gen,
  input  wire logic        halt_in,
  input  wire logic        mode_terminating,
  input  wire logic        step_done,
  input  wire logic        motion_stopped,
  // switch results
  output logic             positive_limit_active,
  output logic             ref_switch_active,
  // jog command
  output logic             jog_run,
  output logic             jog_step_go,
  output logic [31:0]      jog_step_out,
  output logic             jog_dir_neg,
  output logic [15:0]      jog_speed,
  // halt and braking
  output logic             halt_active,
  output logic             halt_torque_ramp,
  output logic [31:0]      halt_decel_out,
  output logic             brake_limit_en,
  output logic [15:0]      brake_current_limit
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  function automatic logic [15:0] clamp_to(input logic [15:0] v,
                                           input logic [15:0] lim);
    clamp_to = (v > lim) ? lim : v;
  endfunction : clamp_to

  function automatic logic eval_switch(input logic [15:0] mode,
                                       input logic raw);
    case (mode)
      `DJLH_EVAL_NC: eval_switch = !raw;
      `DJLH_EVAL_NO: eval_switch = raw;
      default:       eval_switch = 1'b0;
    endcase
  endfunction : eval_switch

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // ------------------------------------------------------------
  // parameter registers
  // ------------------------------------------------------------
  logic [15:0] reference_switch_eval_q;
  logic [15:0] positive_limit_eval_q;
  logic [15:0] halt_decel_type_q;
  logic [15:0] halt_braking_current_q;
  logic [15:0] jog_request_q;
  logic [15:0] jog_speed_low_q;
  logic [15:0] jog_speed_high_q;
  logic [31:0] jog_step_distance_q;
  logic [15:0] jog_wait_time_q;
  logic [15:0] wlo;
  logic        wr_ok;
  logic        hit;

  assign wlo = par_wdata[15:0];

  always_comb begin
    hit   = 1'b1;
    wr_ok = 1'b0;
    case (par_addr)
      `DJLH_ADDR_POSITIVE_LIMIT_INPUT_EVAL:
        wr_ok = in_range(wlo, `DJLH_EVAL_OFF, `DJLH_EVAL_NO); // RULE1
      `DJLH_ADDR_REF_EVAL:
        wr_ok = in_range(wlo, `DJLH_EVAL_NC, `DJLH_EVAL_NO); // RULE2
      `DJLH_ADDR_HALT_TYPE:
        wr_ok = (wlo == `DJLH_HALT_DECEL) ||
                (wlo == `DJLH_HALT_TORQUE); // RULE10
      `DJLH_ADDR_HALT_CUR:
        wr_ok = (wlo <= current_ceiling); // RULE14
      `DJLH_ADDR_JOG_REQ:
        wr_ok = (wlo <= `DJLH_JOG_REQ_MAX);
      `DJLH_ADDR_JOG_SLOW:
        wr_ok = in_range(wlo, `DJLH_SPEED_MIN, `DJLH_SPEED_MAX); // RULE6
      `DJLH_ADDR_JOG_FAST:
        wr_ok = in_range(wlo, `DJLH_SPEED_MIN, `DJLH_SPEED_MAX); // RULE5
      `DJLH_ADDR_JOG_STEP:
        wr_ok = !par_wdata[31]; // RULE8
      `DJLH_ADDR_JOG_WAIT:
        wr_ok = in_range(wlo, `DJLH_WAIT_MIN, `DJLH_WAIT_MAX); // RULE9
      default: begin
        hit   = 1'b0;
        wr_ok = 1'b0;
      end
    endcase
    // 16-bit settings carry nothing above bit 15
    if (par_addr != `DJLH_ADDR_JOG_STEP && par_wdata[31:16] != 16'h0000) begin
      wr_ok = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reference_switch_eval_q <= `DJLH_RST_REF_EVAL;
      positive_limit_eval_q   <= `DJLH_RST_POSITIVE_LIMIT_INPUT_EVAL;
      halt_decel_type_q       <= `DJLH_RST_HALT_TYPE;
      halt_braking_current_q  <= HALT_CUR_RST;
      jog_speed_low_q         <= `DJLH_RST_JOG_SLOW;
      jog_speed_high_q        <= `DJLH_RST_JOG_FAST;
      jog_step_distance_q     <= `DJLH_RST_JOG_STEP;
      jog_wait_time_q         <= `DJLH_RST_JOG_WAIT;
    end else if (par_wr && wr_ok) begin
      case (par_addr)
        `DJLH_ADDR_REF_EVAL:  reference_switch_eval_q <= wlo;
        `DJLH_ADDR_POSITIVE_LIMIT_INPUT_EVAL: positive_limit_eval_q   <= wlo;
        `DJLH_ADDR_HALT_TYPE: halt_decel_type_q       <= wlo;
        `DJLH_ADDR_HALT_CUR:  halt_braking_current_q  <= wlo;
        `DJLH_ADDR_JOG_SLOW:  jog_speed_low_q         <= wlo;
        `DJLH_ADDR_JOG_FAST:  jog_speed_high_q        <= wlo;
        `DJLH_ADDR_JOG_STEP:  jog_step_distance_q     <= par_wdata;
        `DJLH_ADDR_JOG_WAIT:  jog_wait_time_q         <= wlo;
        default: begin
        end
      endcase
    end
  end

  // jog word is volatile; cleared at reset, not kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      jog_request_q <= `DJLH_RST_JOG_REQ;
    end else if (par_wr && wr_ok && par_addr == `DJLH_ADDR_JOG_REQ) begin
      jog_request_q <= wlo;
    end
  end

  // ------------------------------------------------------------
  // read answer and handshake
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      par_rdata <= 32'h0000_0000;
    end else if (par_rd) begin
      case (par_addr)
        `DJLH_ADDR_REF_EVAL:  par_rdata <= {16'h0000, reference_switch_eval_q};
        `DJLH_ADDR_POSITIVE_LIMIT_INPUT_EVAL: par_rdata <= {16'h0000, positive_limit_eval_q};
        `DJLH_ADDR_HALT_TYPE: par_rdata <= {16'h0000, halt_decel_type_q};
        `DJLH_ADDR_HALT_CUR:  par_rdata <= {16'h0000, halt_braking_current_q};
        `DJLH_ADDR_JOG_REQ:   par_rdata <= {16'h0000, jog_request_q};
        `DJLH_ADDR_JOG_SLOW:  par_rdata <= {16'h0000, jog_speed_low_q};
        `DJLH_ADDR_JOG_FAST:  par_rdata <= {16'h0000, jog_speed_high_q};
        `DJLH_ADDR_JOG_STEP:  par_rdata <= jog_step_distance_q;
        `DJLH_ADDR_JOG_WAIT:  par_rdata <= {16'h0000, jog_wait_time_q};
        default:              par_rdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      par_ack <= 1'b0;
      par_err <= 1'b0;
    end else begin
      par_ack <= par_rd || par_wr;
      par_err <= (par_rd && !hit) || (par_wr && !wr_ok);
    end
  end

  // ------------------------------------------------------------
  // switch evaluation
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      positive_limit_active <= 1'b0;
      ref_switch_active     <= 1'b0;
    end else begin
      positive_limit_active <= eval_switch(positive_limit_eval_q,
                                           positive_limit_input); // RULE1
      ref_switch_active     <= homing_active &&
                               eval_switch(reference_switch_eval_q,
                                           ref_switch_input); // RULE3
    end
  end

  // ------------------------------------------------------------
  // millisecond enable
  // ------------------------------------------------------------
  logic [31:0] ms_div_q;
  logic        ms_tick;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_div_q <= 32'h0000_0000;
    end else if (ms_div_q == 32'(MS_CYCLES - 1)) begin
      ms_div_q <= 32'h0000_0000;
    end else begin
      ms_div_q <= ms_div_q + 32'h0000_0001;
    end
  end

  assign ms_tick = (ms_div_q == 32'(MS_CYCLES - 1));

  // ------------------------------------------------------------
  // jog sequencing
  // ------------------------------------------------------------
  djlh_pkg::djlh_jog_cfg_t   jog_cfg;
  djlh_pkg::djlh_motion_t    motion;
  logic [15:0]               speed_sel;

  assign jog_cfg.step_dist = jog_step_distance_q;
  assign jog_cfg.wait_ms   = jog_wait_time_q;

  djlh_jog_seq u_seq (
    .clk            (clk),
    .rst_n          (rst_n),
    .dir_pos        (jog_request_q[`DJLH_JOG_POS_BIT]), // RULE4
    .dir_neg        (jog_request_q[`DJLH_JOG_NEG_BIT]), // RULE4
    .cfg            (jog_cfg),
    .ms_tick        (ms_tick),
    .step_done      (step_done),
    .motion_stopped (motion_stopped),
    .motion         (motion),
    .state          ()
  );

  // clamp follows the live maximum so a later cut still applies
  assign speed_sel = jog_request_q[`DJLH_JOG_FAST_BIT] ?
                     jog_speed_high_q : jog_speed_low_q; // RULE4

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      jog_run      <= 1'b0;
      jog_step_go  <= 1'b0;
      jog_step_out <= 32'h0000_0000;
      jog_dir_neg  <= 1'b0;
      jog_speed    <= 16'h0000;
    end else begin
      jog_run      <= motion.run;
      jog_step_go  <= motion.step_go;
      jog_step_out <= jog_step_distance_q;
      jog_dir_neg  <= motion.neg;
      jog_speed    <= clamp_to(speed_sel, max_ramp_speed); // RULE7
    end
  end

  // ------------------------------------------------------------
  // halt reaction and braking current
  // ------------------------------------------------------------
  logic halt_any;
  logic torque_sel;

  assign halt_any   = halt_in || motion.halt;
  // no profile generator means no ramp to follow: torque ramp is forced
  assign torque_sel = (halt_decel_type_q == `DJLH_HALT_TORQUE) ||
                      !mode_has_profile_gen; // RULE10 RULE12

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_active         <= 1'b0;
      halt_torque_ramp    <= 1'b1;
      halt_decel_out      <= 32'h0000_0000;
      brake_limit_en      <= 1'b0;
      brake_current_limit <= 16'h0000;
    end else begin
      halt_active         <= halt_any; // RULE15
      halt_torque_ramp    <= torque_sel; // RULE12
      halt_decel_out      <= decel_ramp_setting; // RULE11
      brake_limit_en      <= halt_any || mode_terminating; // RULE13
      brake_current_limit <= halt_braking_current_q; // RULE11 RULE14
    end
  end

endmodule : djlh_ctrl

`default_nettype wire

//--- design/djlh_regs.svh
// Purpose : register offsets, field positions, reset values and timing
// Assumes : parameter addresses are the printed fieldbus numbers
// Notes   : definitions only
//
// Contract
// RULE1 - Positive limit evaluation decodes 0 as ignored, 1 as NC, 2 as NO.
// RULE2 - Reference evaluation accepts only 1 (NC, default) or 2 (NO).
// RULE3 - The reference input counts only while homing is running.
// RULE4 - Jog word bit 0 is positive, bit 1 negative, bit 2 fast when set.
// RULE5 - Fast jog speed is held in 1..13200 per minute, default 180.
// RULE6 - Slow jog speed is held in 1..13200 per minute, default 60.
// RULE7 - Both jog speeds are clamped to the present maximum ramp speed.
// RULE8 - Step distance 0 starts continuous jog, above 0 steps that far first.
// RULE9 - Wait time 1..32767 ms (default 500) applies only after a step.
// RULE10 - Halt reaction 1 means deceleration ramp, 3 torque ramp (default).
// RULE11 - Halt ramp comes from the decel setting or the halt current limit.
// RULE12 - Deceleration ramp only with a profile generator, else torque ramp.
// RULE13 - Braking current after halt or mode end is limited to the halt limit.
// RULE14 - Halt current limit is an unsigned count of 0.01 A peak steps.
// RULE15 - Clearing the direction bit stops jog by the halt reaction; no jog
// while neither or both direction bits are set.
`ifndef DJLH_REGS_SVH
`define DJLH_REGS_SVH

// ------------------------------------------------------------
// parameter addresses
// ------------------------------------------------------------
`define DJLH_ADDR_REF_EVAL     16'h061c
`define DJLH_ADDR_POSITIVE_LIMIT_INPUT_EVAL    16'h0620
`define DJLH_ADDR_HALT_TYPE    16'h062e
`define DJLH_ADDR_HALT_CUR     16'h110c
`define DJLH_ADDR_JOG_REQ      16'h1b12
`define DJLH_ADDR_JOG_SLOW     16'h2908
`define DJLH_ADDR_JOG_FAST     16'h290a
`define DJLH_ADDR_JOG_STEP     16'h290e
`define DJLH_ADDR_JOG_WAIT     16'h2910

// ------------------------------------------------------------
// field positions and encodings
// ------------------------------------------------------------
`define DJLH_JOG_POS_BIT       0
`define DJLH_JOG_NEG_BIT       1
`define DJLH_JOG_FAST_BIT      2
`define DJLH_EVAL_OFF          16'h0000
`define DJLH_EVAL_NC           16'h0001
`define DJLH_EVAL_NO           16'h0002
`define DJLH_HALT_DECEL        16'h0001
`define DJLH_HALT_TORQUE       16'h0003

// ------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------
`define DJLH_RST_REF_EVAL      16'h0001
`define DJLH_RST_POSITIVE_LIMIT_INPUT_EVAL     16'h0001
`define DJLH_RST_HALT_TYPE     16'h0003
`define DJLH_RST_JOG_REQ       16'h0000
`define DJLH_RST_JOG_SLOW      16'h003c
`define DJLH_RST_JOG_FAST      16'h00b4
`define DJLH_RST_JOG_STEP      32'h0000_0014
`define DJLH_RST_JOG_WAIT      16'h01f4
`define DJLH_JOG_REQ_MAX       16'h0007
`define DJLH_SPEED_MIN         16'h0001
`define DJLH_SPEED_MAX         16'h3390
`define DJLH_WAIT_MIN          16'h0001
`define DJLH_WAIT_MAX          16'h7fff

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define DJLH_CLK_HZ            25000000
`define DJLH_MS_PER_S          1000
`define DJLH_MS_CYCLES         (`DJLH_CLK_HZ / `DJLH_MS_PER_S)

`endif

//--- design/djlh_pkg.sv
// Purpose : shared types of the jog, limit and halt control
// Assumes : nothing beyond the register header
// Notes   : one-hot jog sequencer states
`default_nettype none

package djlh_pkg;

  typedef enum logic [4:0] {
    DJLH_IDLE = 5'b00001,
    DJLH_STEP = 5'b00010,
    DJLH_WAIT = 5'b00100,
    DJLH_RUN  = 5'b01000,
    DJLH_STOP = 5'b10000
  } djlh_jog_state_t;

  typedef struct packed {
    logic [31:0] step_dist;
    logic [15:0] wait_ms;
  } djlh_jog_cfg_t;

  typedef struct packed {
    logic run;
    logic step_go;
    logic neg;
    logic halt;
  } djlh_motion_t;

endpackage : djlh_pkg

`default_nettype wire

//--- design/djlh_jog_seq.sv
// Purpose : jog sequencer: optional step, wait, continuous run, stop
// Assumes : ms_tick is a one-cycle pulse once per millisecond
// Notes   : direction sampled when a jog starts
`default_nettype none

module djlh_jog_seq (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // request and configuration
  input  wire logic                    dir_pos,
  input  wire logic                    dir_neg,
  input  wire djlh_pkg::djlh_jog_cfg_t cfg,
  input  wire logic                    ms_tick,
  // motion feedback
  input  wire logic                    step_done,
  input  wire logic                    motion_stopped,
  // motion command
  output djlh_pkg::djlh_motion_t       motion,
  output djlh_pkg::djlh_jog_state_t    state
);

  djlh_pkg::djlh_jog_state_t state_q;
  logic                      neg_q;
  logic                      step_go_q;
  logic [15:0]               ms_cnt_q;
  logic                      req_ok;
  logic                      abort;

  assign req_ok = dir_pos ^ dir_neg; // RULE15
  // a reversal counts as release: stop first, then restart the other way
  assign abort  = !req_ok || (dir_neg != neg_q); // RULE15

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= djlh_pkg::DJLH_IDLE;
    end else begin
      case (state_q)
        djlh_pkg::DJLH_IDLE: begin
          if (req_ok) begin
            if (cfg.step_dist == 32'h0000_0000) begin
              state_q <= djlh_pkg::DJLH_RUN; // RULE8
            end else begin
              state_q <= djlh_pkg::DJLH_STEP; // RULE8
            end
          end
        end
        djlh_pkg::DJLH_STEP: begin
          if (abort) begin
            state_q <= djlh_pkg::DJLH_STOP;
          end else if (step_done) begin
            state_q <= djlh_pkg::DJLH_WAIT;
          end
        end
        djlh_pkg::DJLH_WAIT: begin
          if (abort) begin
            state_q <= djlh_pkg::DJLH_STOP;
          end else if (ms_tick && (ms_cnt_q + 16'h0001 >= cfg.wait_ms)) begin
            state_q <= djlh_pkg::DJLH_RUN; // RULE9
          end
        end
        djlh_pkg::DJLH_RUN: begin
          if (abort) begin
            state_q <= djlh_pkg::DJLH_STOP; // RULE15
          end
        end
        djlh_pkg::DJLH_STOP: begin
          if (motion_stopped) begin
            state_q <= djlh_pkg::DJLH_IDLE;
          end
        end
        default: begin
          state_q <= djlh_pkg::DJLH_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // direction latch, step pulse, wait counter
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      neg_q <= 1'b0;
    end else if (state_q == djlh_pkg::DJLH_IDLE && req_ok) begin
      neg_q <= dir_neg; // RULE4
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_go_q <= 1'b0;
    end else begin
      step_go_q <= (state_q == djlh_pkg::DJLH_IDLE) && req_ok &&
                   (cfg.step_dist != 32'h0000_0000);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_q <= 16'h0000;
    end else if (state_q != djlh_pkg::DJLH_WAIT) begin
      ms_cnt_q <= 16'h0000;
    end else if (ms_tick) begin
      ms_cnt_q <= ms_cnt_q + 16'h0001; // RULE9
    end
  end

  assign motion.run     = (state_q == djlh_pkg::DJLH_RUN);
  assign motion.step_go = step_go_q;
  assign motion.neg     = neg_q;
  assign motion.halt    = (state_q == djlh_pkg::DJLH_STOP); // RULE15
  assign state          = state_q;

endmodule : djlh_jog_seq

`default_nettype wire

//--- dv/djlh_ctrl_assertions.sv
// Purpose : port checks of djlh_ctrl
// Assumes : answers registered one cycle after their cause
// Notes   : attached by bind below
`default_nettype none

module djlh_ctrl_assertions (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // parameter port
  input wire logic [15:0] par_addr,
  input wire logic        par_wr,
  input wire logic [31:0] par_wdata,
  input wire logic        par_err,
  // context
  input wire logic        homing_active,
  input wire logic [15:0] max_ramp_speed,
  input wire logic        mode_has_profile_gen,
  input wire logic        mode_terminating,
  // results
  input wire logic        ref_switch_active,
  input wire logic        jog_run,
  input wire logic [15:0] jog_speed,
  input wire logic        halt_active,
  input wire logic        halt_torque_ramp,
  input wire logic        brake_limit_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ----
  // checks
  // ----
  a_positive_limit_input_code_range: assert property (
    par_wr && par_addr == 16'h0620 && par_wdata > 32'h2 |=> par_err)
    else $error("limit eval code above 2 taken");
  a_ref_code_range: assert property (
    par_wr && par_addr == 16'h061c && (par_wdata == 32'h0 ||
    par_wdata > 32'h2) |=> par_err) else $error("ref eval code taken");
  a_halt_code_range: assert property (
    par_wr && par_addr == 16'h062e && par_wdata != 32'h1 &&
    par_wdata != 32'h3 |=> par_err) else $error("halt type code taken");
  a_ref_needs_homing: assert property (
    !homing_active |=> !ref_switch_active) else $error("ref seen idle");
  a_jog_speed_clamp: assert property (
    $stable(max_ramp_speed) |-> jog_speed <= max_ramp_speed)
    else $error("jog speed above max ramp speed");
  a_torque_no_profile: assert property (
    !mode_has_profile_gen |=> halt_torque_ramp) else $error("decel ramp");
  a_brake_on_mode_end: assert property (
    mode_terminating |=> brake_limit_en) else $error("no braking limit");
  a_jog_stop_halts: assert property (
    $fell(jog_run) |-> halt_active) else $error("jog ended without halt");

  c_jog_run: cover property (jog_run);
  c_halt_end: cover property ($fell(halt_active));
  c_refused: cover property (par_err);
endmodule : djlh_ctrl_assertions

bind djlh_ctrl djlh_ctrl_assertions i_chk (
  .clk, .rst_b, .par_addr, .par_wr, .par_wdata, .par_err, .homing_active,
  .max_ramp_speed, .mode_has_profile_gen, .mode_terminating,
  .ref_switch_active, .jog_run, .jog_speed, .halt_active,
  .halt_torque_ramp, .brake_limit_en);
`default_nettype wire

//--- dv/djlh_motion_model.sv
// Purpose : motion stage answering the jog commands
// Assumes : lag of 1 or more sets how slowly the axis reacts
// Notes   : behavioural only
`default_nettype none

module djlh_motion_model (
  // clock and command
  input wire logic       clk,
  input wire logic       jog_run,
  input wire logic       jog_step_go,
  input wire logic [3:0] lag,
  // feedback
  output logic           step_done,
  output logic           motion_stopped
);
  logic [3:0] step_q = 4'h0, coast_q = 4'h0;

  always_ff @(posedge clk) begin
    if (jog_step_go) step_q <= lag;
    else if (step_q != 4'h0) step_q <= step_q - 4'h1;
  end

  // axis coasts for lag cycles after every move ends
  always_ff @(posedge clk) begin
    if (jog_run || step_q != 4'h0) coast_q <= lag;
    else if (coast_q != 4'h0) coast_q <= coast_q - 4'h1;
  end

  assign step_done = step_q == 4'h1;
  assign motion_stopped = coast_q == 4'h0 && !jog_run && step_q == 4'h0;
endmodule : djlh_motion_model
`default_nettype wire

//--- dv/djlh_ctrl_tb_top.sv
// Purpose : self-checking bench of djlh_ctrl
// Assumes : millisecond tick cut to 5 cycles
// Notes   : seeded random values with fixed corners
`default_nettype none

module djlh_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, par_wr = 0, par_rd = 0, halt_in = 0;
  logic positive_limit_input = 0, ref_switch_input = 0, homing_active = 0;
  logic mode_has_profile_gen = 0, mode_terminating = 0;
  logic step_done, motion_stopped, positive_limit_active, ref_switch_active;
  logic par_ack, par_err, jog_run, jog_step_go, jog_dir_neg, halt_active;
  logic halt_torque_ramp, brake_limit_en;
  logic [3:0] lag = 4'h8;
  logic [15:0] par_addr = '0, max_ramp_speed = 16'h3390;
  logic [15:0] current_ceiling = 16'h0800, jog_speed, brake_current_limit;
  logic [31:0] par_wdata = '0, decel_ramp_setting = '0, par_rdata;
  logic [31:0] jog_step_out, halt_decel_out;
  int fails = 0, n_checks = 0;
  logic [15:0] ra [9] = '{16'h061c, 16'h0620, 16'h062e, 16'h110c, 16'h1b12,
                          16'h2908, 16'h290a, 16'h290e, 16'h2910};
  logic [31:0] rv [9] = '{32'h1, 32'h1, 32'h3, 32'h64, 32'h0, 32'h3c,
                          32'hb4, 32'h14, 32'h1f4};
  int bi [10] = '{1, 0, 0, 2, 5, 6, 7, 8, 8, 3};
  logic [31:0] bv [10] = '{32'h3, 32'h0, 32'h3, 32'h2, 32'h0, 32'h3391,
                           32'h8000_0000, 32'h0, 32'h8000, 32'h801};

  djlh_ctrl #(.MS_CYCLES(5)) i_dut (.*);
  djlh_motion_model i_motion (.*);

  initial forever #20 clk = ~clk;

  task automatic conclude();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  initial begin
    #800000;
    fails++;
    conclude();
  end

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  // one-cycle strobe; idle edge before the next one
  task automatic acc(logic wr, logic [15:0] a, logic [31:0] d,
                     output logic e, output logic [31:0] q);
    par_addr = a;
    par_wdata = d;
    par_wr = wr;
    par_rd = !wr;
    cyc(1);
    e = par_err;
    q = par_rdata;
    chk("ack", par_ack, 1'b1);
    par_wr = 0;
    par_rd = 0;
    cyc(1);
  endtask : acc

  task automatic waitfor(string what, ref logic s, input logic v,
                         output int n);
    for (n = 0; s !== v && n < 60; n++) cyc(1);
    chk(what, s, v);
  endtask : waitfor

  function automatic logic sw(logic [1:0] ev, logic in);
    return (ev == 2'h1) ? !in : (ev == 2'h2) ? in : 1'b0;
  endfunction : sw

  initial begin
    int n;
    logic e;
    logic [31:0] q;
    logic [15:0] s, f, v;
    void'($urandom(32'h7c1a));
    repeat (12) @(posedge clk);
    #1 rst_b = 1;
    cyc(3);
    for (int i = 0; i < 9; i++) begin
      acc(0, ra[i], '0, e, q);
      chk("reset value", q, rv[i]);
    end
    acc(0, 16'h0622, '0, e, q);
    chk("unmapped", e, 1'b1);
    for (int i = 0; i < 10; i++) begin
      acc(1, ra[bi[i]], bv[i], e, q);
      chk("refused", e, 1'b1);
      acc(0, ra[bi[i]], '0, e, q);
      chk("kept", q, rv[bi[i]]);
    end
    for (int i = 0; i < 20; i++) begin
      s = (i == 0) ? 16'h3390 : 16'($urandom_range(1, 13200));
      f = 16'($urandom_range(1, 13200));
      max_ramp_speed = (i == 1) ? 16'h1 : 16'($urandom_range(1, 13200));
      v = 16'($urandom_range(0, 1)) << 2;
      acc(1, 16'h2908, {16'h0, s}, e, q);
      acc(1, 16'h290a, {16'h0, f}, e, q);
      acc(1, 16'h1b12, {16'h0, v}, e, q);
      cyc(2);
      s = v[2] ? f : s;
      chk("speed", jog_speed, s > max_ramp_speed ? max_ramp_speed : s);
      chk("no jog", jog_run, 1'b0);
    end
    for (int ev = 0; ev < 3; ev++) begin
      for (int k = 0; k < 4; k++) begin
        acc(1, 16'h0620, 32'(ev), e, q);
        if (ev != 0) acc(1, 16'h061c, 32'(ev), e, q);
        positive_limit_input = k[0];
        ref_switch_input = k[0];
        homing_active = k[1];
        cyc(2);
        chk("limit", positive_limit_active, sw(2'(ev), k[0]));
        s = (ev == 0) ? 16'h1 : 16'(ev);
        chk("ref", ref_switch_active, k[1] & sw(s[1:0], k[0]));
      end
    end
    acc(1, 16'h290e, '0, e, q);
    for (int d = 1; d < 4; d++) begin
      acc(1, 16'h1b12, 32'(d), e, q);
      cyc(4);
      chk("run", jog_run, d != 3);
      if (d != 3) chk("dir", jog_dir_neg, d == 2);
      acc(1, 16'h1b12, '0, e, q);
      cyc(1);
      if (d != 3) chk("stopping", halt_active, 1'b1);
      waitfor("halt end", halt_active, 1'b0, n);
    end
    acc(1, 16'h290e, 32'h7, e, q);
    acc(1, 16'h2910, 32'h3, e, q);
    acc(1, 16'h1b12, 32'h6, e, q);
    waitfor("step go", jog_step_go, 1'b1, n);
    chk("step", jog_step_out, 32'h7);
    waitfor("run after wait", jog_run, 1'b1, n);
    chk("wait span", n >= 15 && n <= 35, 1'b1);
    acc(1, 16'h1b12, '0, e, q);
    waitfor("halt end", halt_active, 1'b0, n);
    lag = 4'h1;
    decel_ramp_setting = $urandom;
    for (int k = 0; k < 4; k++) begin
      mode_has_profile_gen = k[0];
      acc(1, 16'h062e, k[1] ? 32'h3 : 32'h1, e, q);
      s = 16'($urandom_range(0, 16'h0800));
      acc(1, 16'h110c, {16'h0, s}, e, q);
      halt_in = k != 3;
      mode_terminating = k == 3;
      cyc(2);
      chk("torque", halt_torque_ramp, k != 1);
      chk("brake en", brake_limit_en, 1'b1);
      chk("brake lim", brake_current_limit, s);
      chk("decel", halt_decel_out, decel_ramp_setting);
      halt_in = 0;
      mode_terminating = 0;
      cyc(4);
    end
    conclude();
  end
endmodule : djlh_ctrl_tb_top
`default_nettype wire
